// >>> hw/ewac_wait_config.sv
/*
 * APB register bank with SDRAM idle-gap enforcement and card-area strobe
 * timing for the external bus controller.
 * Assumes refresh, self-refresh exit and card requests are one-cycle pulses
 * from logic on the same clock, and that the controller holds off SDRAM
 * commands while sdramCmdAllowed is low.
 */
`timescale 1ns/10ps
`include "ewac_consts.svh"

// Notes on behaviour
// - idle gap after refresh set by code
// - same idle gap after self-refresh exit
// - SDRAM wait bit 2 reads zero
// - space attributes only apply in card mode
// - A25 high uses upper attribute bit
// - A25 low uses lower attribute bit
// - strobe follows address by code bits 2:0 plus half
// - card register reserved bits read zero
module ewac_wait_config import ewac_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // APB slave
   input wire logic [`EWAC_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // SDRAM command gating
   input wire logic refreshIssued,
   input wire logic selfRefreshExit,
   output logic sdramCmdAllowed,
   // Card area mode from bus controller configuration
   input wire logic area5CardMode,
   input wire logic area6CardMode,
   // Card access
   input wire logic cardStart,
   input wire ewac_card_req_t cardReq,
   input wire logic cardEnd,
   output logic cardAddrValid,
   output logic cardIoCycle,
   output logic cardRdStrobe,
   output logic cardWrStrobe
);
   logic [1:0] idleCode, next_idleCode;
   ewac_card_cfg_t card5, next_card5, card6, next_card6;
   logic [31:0] next_prdata;
   ewac_card_state_t cardState, next_cardState;
   logic cardWrite, next_cardWrite;
   logic next_cardIoCycle, next_cardAddrValid;
   logic next_cardRdStrobe, next_cardWrStrobe;
   logic idleEvent, idleZero, cardLoad, delayZero, strobeArm;
   logic [3:0] idleLoadValue, delayCount;
   logic regWrite, regRead;
   ewac_card_cfg_t selCfg;
   logic selMode;

   function automatic logic [3:0] idleCycles(input logic [1:0] code);
      unique case (code)
         2'h0: idleCycles = `EWAC_IDLE_00;
         2'h1: idleCycles = `EWAC_IDLE_01;
         2'h2: idleCycles = `EWAC_IDLE_10;
         2'h3: idleCycles = `EWAC_IDLE_11;
      endcase
   endfunction

   // Only the live fields are placed; all else reads as zero
   function automatic logic [31:0] cardWord(input ewac_card_cfg_t c);
      cardWord = 32'h0;
      cardWord[`EWAC_SA_HI_BIT] = c.spaceAttrUpperHalf;
      cardWord[`EWAC_SA_LO_BIT] = c.spaceAttrLowerHalf;
      cardWord[`EWAC_DLY_MSB:`EWAC_DLY_LSB] = c.strobeDelay;
   endfunction

   function automatic ewac_card_cfg_t cardFields(input logic [31:0] w);
      cardFields.spaceAttrUpperHalf = w[`EWAC_SA_HI_BIT];
      cardFields.spaceAttrLowerHalf = w[`EWAC_SA_LO_BIT];
      cardFields.strobeDelay = w[`EWAC_DLY_MSB:`EWAC_DLY_LSB];
   endfunction

   // Register bus: zero wait states, read data captured in setup phase
   assign pready = 1'b1;
   assign regWrite = psel && penable && pwrite;
   assign regRead = psel && !penable && !pwrite;
   assign pslverr = psel && penable && !(paddr == `EWAC_OFS_SDRAM_WAIT ||
      paddr == `EWAC_OFS_CARD5 || paddr == `EWAC_OFS_CARD6 ||
      paddr == `EWAC_OFS_STATUS);

   always_comb begin
      next_idleCode = idleCode;
      next_card5 = card5;
      next_card6 = card6;
      next_prdata = prdata;
      if (regWrite) begin
         unique case (paddr)
            `EWAC_OFS_SDRAM_WAIT:
               next_idleCode = pwdata[`EWAC_IDLE_MSB:`EWAC_IDLE_LSB];
            `EWAC_OFS_CARD5: next_card5 = cardFields(pwdata);
            `EWAC_OFS_CARD6: next_card6 = cardFields(pwdata);
            default: next_idleCode = idleCode;
         endcase
      end
      if (regRead) begin
         next_prdata = 32'h0;
         unique case (paddr)
            `EWAC_OFS_SDRAM_WAIT: begin
               next_prdata[`EWAC_IDLE_MSB:`EWAC_IDLE_LSB] = idleCode;
            end
            `EWAC_OFS_CARD5: next_prdata = cardWord(card5);
            `EWAC_OFS_CARD6: next_prdata = cardWord(card6);
            `EWAC_OFS_STATUS: begin
               next_prdata[`EWAC_ST_SDRAM_BUSY] = !sdramCmdAllowed;
               next_prdata[`EWAC_ST_CARD_BUSY] = (cardState != CARD_IDLE);
               next_prdata[`EWAC_ST_CARD_IO] = cardIoCycle;
            end
            default: next_prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         idleCode <= `EWAC_IDLE_RST;
         card5 <= '{`EWAC_SA_RST, `EWAC_SA_RST, `EWAC_DLY_RST};
         card6 <= '{`EWAC_SA_RST, `EWAC_SA_RST, `EWAC_DLY_RST};
         prdata <= 32'h0;
      end else begin
         idleCode <= next_idleCode;
         card5 <= next_card5;
         card6 <= next_card6;
         prdata <= next_prdata;
      end
   end

   // SDRAM idle gap: N cycles from the event to the next allowed command
   assign idleEvent = refreshIssued || selfRefreshExit;
   assign idleLoadValue = idleCycles(idleCode) - 4'h1;

   ewac_cycle_timer idleTimer (
      .clock(clock),
      .arst_n(arst_n),
      .load(idleEvent),
      .loadValue(idleLoadValue),
      .count(),
      .zero(idleZero)
   );

   assign sdramCmdAllowed = idleZero && !idleEvent;

   // Card access sequencing
   assign selCfg = cardReq.area6 ? card6 : card5;
   assign selMode = cardReq.area6 ? area6CardMode : area5CardMode;
   assign cardLoad = cardStart && (cardState == CARD_IDLE);

   // Top delay bit dropped: prohibited codes cannot stretch the count
   ewac_cycle_timer delayTimer (
      .clock(clock),
      .arst_n(arst_n),
      .load(cardLoad),
      .loadValue({1'b0, selCfg.strobeDelay[2:0]}),
      .count(delayCount),
      .zero(delayZero)
   );

   always_comb begin
      next_cardState = cardState;
      next_cardWrite = cardWrite;
      next_cardIoCycle = cardIoCycle;
      next_cardAddrValid = cardAddrValid;
      unique case (cardState)
         CARD_IDLE: begin
            if (cardStart) begin
               next_cardState = CARD_DELAY;
               next_cardWrite = cardReq.write;
               next_cardAddrValid = 1'b1;
               next_cardIoCycle = selMode && (cardReq.a25 ?
                  selCfg.spaceAttrUpperHalf : selCfg.spaceAttrLowerHalf);
            end
         end
         CARD_DELAY: begin
            if (cardEnd) begin
               next_cardState = CARD_IDLE;
               next_cardAddrValid = 1'b0;
            end else if (delayZero) begin
               next_cardState = CARD_STROBE;
            end
         end
         CARD_STROBE: begin
            if (cardEnd) begin
               next_cardState = CARD_IDLE;
               next_cardAddrValid = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cardState <= CARD_IDLE;
         cardWrite <= 1'b0;
         cardIoCycle <= 1'b0;
         cardAddrValid <= 1'b0;
      end else begin
         cardState <= next_cardState;
         cardWrite <= next_cardWrite;
         cardIoCycle <= next_cardIoCycle;
         cardAddrValid <= next_cardAddrValid;
      end
   end

   // Strobes launch on the falling edge, giving the extra half cycle
   assign strobeArm = !cardEnd && ((cardState == CARD_STROBE) ||
      (cardState == CARD_DELAY && delayZero));

   always_comb begin
      next_cardRdStrobe = strobeArm && !cardWrite;
      next_cardWrStrobe = strobeArm && cardWrite;
   end

   always_ff @(negedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cardRdStrobe <= 1'b0;
         cardWrStrobe <= 1'b0;
      end else begin
         cardRdStrobe <= next_cardRdStrobe;
         cardWrStrobe <= next_cardWrStrobe;
      end
   end

   // Helper: cycles since the last idle event, saturating
   logic [3:0] gapCount, needCycles;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gapCount <= 4'hF;
         needCycles <= 4'h0;
      end else if (idleEvent) begin
         gapCount <= 4'h1;
         needCycles <= idleCycles(idleCode);
      end else if (gapCount != 4'hF) begin
         gapCount <= gapCount + 4'h1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence refreshCode0;
      refreshIssued && !selfRefreshExit && idleCode == 2'h0;
   endsequence
   sequence quietCycle;
      !idleEvent;
   endsequence
   sequence cardStartCode3;
      cardLoad && selCfg.strobeDelay == 4'h3 && !cardEnd;
   endsequence

   a_idle_gap_min: assert property (
      sdramCmdAllowed |-> gapCount >= needCycles)
      else $error("SDRAM command inside idle gap");
   a_idle_gap_release: assert property (
      refreshCode0 ##1 quietCycle ##1 quietCycle |-> sdramCmdAllowed)
      else $error("SDRAM command held past 2-cycle gap");
   a_selfref_exit_gap: assert property (
      (selfRefreshExit && idleCode == 2'h3) |=>
         (!sdramCmdAllowed)[*7])
      else $error("Command allowed early after self-refresh exit");
   a_sdram_rsvd_zero: assert property (
      (regRead && paddr == `EWAC_OFS_SDRAM_WAIT) |=> prdata[31:2] == 30'h0)
      else $error("SDRAM wait reserved bits not zero");
   a_card_rsvd_zero: assert property (
      (regRead && (paddr == `EWAC_OFS_CARD5 || paddr == `EWAC_OFS_CARD6))
         |=> prdata[31:22] == 10'h0 && prdata[19:15] == 5'h0)
      else $error("Card reserved bits not zero");
   a_card_mode_gate: assert property (
      (cardLoad && !selMode) |=> !cardIoCycle)
      else $error("I/O cycle outside card mode");
   a_space_upper: assert property (
      (cardLoad && selMode && cardReq.a25) |=>
         cardIoCycle == $past(selCfg.spaceAttrUpperHalf))
      else $error("Upper attribute not applied");
   a_space_lower: assert property (
      (cardLoad && selMode && !cardReq.a25) |=>
         cardIoCycle == $past(selCfg.spaceAttrLowerHalf))
      else $error("Lower attribute not applied");
   a_strobe_delay3: assert property (
      cardStartCode3 ##1 (!cardEnd)[*4] |->
         $past(!(cardRdStrobe || cardWrStrobe)) &&
         (cardRdStrobe || cardWrStrobe))
      else $error("Strobe not 3.5 cycles after address");
   a_half_edge: assert property (
      $rose(cardRdStrobe || cardWrStrobe) |->
         strobeArm && cardAddrValid)
      else $error("Strobe not launched on falling edge");
endmodule

// >>> common/ewac_consts.svh
/*
 * Register offsets, field positions, reset values and cycle counts of the
 * external bus area wait configuration block.
 * Assumes inclusion by bare name from design files and the bench.
 */
`ifndef EWAC_CONSTS_SVH
`define EWAC_CONSTS_SVH

// Register byte offsets on the APB side
`define EWAC_ADDR_W 8
`define EWAC_OFS_SDRAM_WAIT 8'h00
`define EWAC_OFS_CARD5 8'h04
`define EWAC_OFS_CARD6 8'h08
`define EWAC_OFS_STATUS 8'h0C

// SDRAM wait register: idle count field at [1:0], bit 2 reserved
`define EWAC_IDLE_LSB 0
`define EWAC_IDLE_MSB 1
`define EWAC_IDLE_RST 2'h0

// Card area registers
`define EWAC_SA_LO_BIT 20
`define EWAC_SA_HI_BIT 21
`define EWAC_DLY_LSB 11
`define EWAC_DLY_MSB 14
`define EWAC_SA_RST 1'h0
`define EWAC_DLY_RST 4'h0

// Status register bits
`define EWAC_ST_SDRAM_BUSY 0
`define EWAC_ST_CARD_BUSY 1
`define EWAC_ST_CARD_IO 2

// Idle cycles per idle count code
`define EWAC_IDLE_00 4'h2
`define EWAC_IDLE_01 4'h3
`define EWAC_IDLE_10 4'h5
`define EWAC_IDLE_11 4'h8

`endif

// >>> common/ewac_pkg.sv
/*
 * Types shared by the wait configuration block and its bench.
 * Assumes the constants header sits beside it in common/.
 */
package ewac_pkg;

   // One card access request from the bus controller
   typedef struct packed {
      logic area6;
      logic a25;
      logic write;
   } ewac_card_req_t;

   // Programmed settings of one card area
   typedef struct packed {
      logic spaceAttrUpperHalf;
      logic spaceAttrLowerHalf;
      logic [3:0] strobeDelay;
   } ewac_card_cfg_t;

   typedef enum logic [1:0] {
      CARD_IDLE,
      CARD_DELAY,
      CARD_STROBE
   } ewac_card_state_t;

endpackage

// >>> hw/ewac_cycle_timer.sv
/*
 * Down counter used for SDRAM idle gaps and card strobe delays.
 * Assumes load is a one-cycle pulse on the same clock.
 */
`timescale 1ns/10ps
module ewac_cycle_timer import ewac_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Control
   input wire logic load,
   input wire logic [3:0] loadValue,
   // State
   output logic [3:0] count,
   output logic zero
);
   logic [3:0] next_count;

   always_comb begin
      next_count = count;
      if (load) begin
         next_count = loadValue;
      end else if (count != 4'h0) begin
         next_count = count - 4'h1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count <= 4'h0;
      end else begin
         count <= next_count;
      end
   end

   assign zero = (count == 4'h0);
endmodule

// >>> sim/ewac_card_model.sv
/*
 * Behavioural card on the far side of the card strobes: counts clock
 * half-cycles from address output to the first strobe.
 * Assumes address changes on rising edges and strobes on falling edges.
 */
`timescale 1ns/10ps
module ewac_card_model (
   // Clock
   input wire logic clock,
   // Card bus as seen by the card
   input wire logic cardAddrValid,
   input wire logic cardRdStrobe,
   input wire logic cardWrStrobe,
   // Measurement
   output logic [4:0] halfCount
);
   // Both edges count, so a half-cycle delay shows as an odd number
   always @(clock) begin
      if (!cardAddrValid)
         halfCount <= 5'h00;
      else if (!(cardRdStrobe | cardWrStrobe))
         halfCount <= halfCount + 5'h01;
   end
endmodule

// >>> sim/ewac_wait_config_bench.sv
/*
 * Self-checking bench: APB register checks, SDRAM idle gaps, card timing.
 * Assumes the package, header, design and card model are compiled first.
 */
`timescale 1ns/10ps
`include "ewac_consts.svh"
module ewac_wait_config_bench import ewac_pkg::*;;
   logic clock, arst_n, psel, penable, pwrite, pready, pslverr, errBit;
   logic refreshIssued, selfRefreshExit, sdramCmdAllowed;
   logic area5CardMode, area6CardMode, cardStart, cardEnd;
   logic cardAddrValid, cardIoCycle, cardRdStrobe, cardWrStrobe;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdVal;
   logic [4:0] halfCount;
   ewac_card_req_t cardReq;
   int errCount, checkCount, cycleCount;
   logic [3:0] idleTab [4] = '{4'h2, 4'h3, 4'h5, 4'h8};

   ewac_wait_config i_ewac_wait_config (.clock(clock), .arst_n(arst_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .refreshIssued(refreshIssued), .selfRefreshExit(selfRefreshExit),
      .sdramCmdAllowed(sdramCmdAllowed), .area5CardMode(area5CardMode),
      .area6CardMode(area6CardMode), .cardStart(cardStart),
      .cardReq(cardReq), .cardEnd(cardEnd), .cardAddrValid(cardAddrValid),
      .cardIoCycle(cardIoCycle), .cardRdStrobe(cardRdStrobe),
      .cardWrStrobe(cardWrStrobe));

   ewac_card_model i_ewac_card_model (.clock(clock),
      .cardAddrValid(cardAddrValid), .cardRdStrobe(cardRdStrobe),
      .cardWrStrobe(cardWrStrobe), .halfCount(halfCount));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Long enough for all tests with a wide margin
   always @(posedge clock) begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == 20000) begin
         errCount++;
         wrap_up();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, exp);
      checkCount++;
      if (seen !== exp) begin
         errCount++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for the answer
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdVal = prdata;
      errBit = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic gap(input logic self, input logic [3:0] exp);
      int n;
      @(posedge clock);
      if (self)
         selfRefreshExit <= 1'b1;
      else
         refreshIssued <= 1'b1;
      #1;
      n = 0;
      while (sdramCmdAllowed !== 1'b1 && n < 20) begin
         n++;
         @(posedge clock);
         refreshIssued <= 1'b0;
         selfRefreshExit <= 1'b0;
         #1;
      end
      check("idle gap", n, 32'(exp));
   endtask

   task automatic card(input logic a6, a25, wr, expIo,
      input logic [2:0] dly);
      int n;
      @(posedge clock);
      cardStart <= 1'b1;
      cardReq <= '{area6: a6, a25: a25, write: wr};
      @(posedge clock);
      cardStart <= 1'b0;
      n = 0;
      while (!(cardRdStrobe | cardWrStrobe) && n < 40) begin
         @(posedge clock);
         n++;
      end
      #1;
      check("io cycle", cardIoCycle, expIo);
      check("strobe delay", halfCount, 32'(dly) * 2 + 1);
      check("strobe kind", {cardWrStrobe, cardRdStrobe}, wr ? 2 : 1);
      apb(1'b0, `EWAC_OFS_STATUS, 32'h0);
      check("card status", rdVal, {29'h0, expIo, 2'b10});
      @(posedge clock);
      cardEnd <= 1'b1;
      @(posedge clock);
      cardEnd <= 1'b0;
      #1;
      check("address drop", cardAddrValid, 0);
   endtask

   initial begin
      arst_n = 1'b0;
      {psel, penable, pwrite, refreshIssued, selfRefreshExit} = 5'h00;
      {area5CardMode, area6CardMode, cardStart, cardEnd} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      cardReq = '0;
      {errCount, checkCount, cycleCount} = '0;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         check("reset value", rdVal, 32'h0);
      end
      apb(1'b1, `EWAC_OFS_SDRAM_WAIT, 32'hFFFFFFFF);
      apb(1'b0, `EWAC_OFS_SDRAM_WAIT, 32'h0);
      check("sdram wait", rdVal, 32'h00000003);
      // Delay code kept legal at 0111
      apb(1'b1, `EWAC_OFS_CARD6, 32'hFFFFBFFF);
      apb(1'b0, `EWAC_OFS_CARD6, 32'h0);
      check("card reserved", rdVal, 32'h00303800);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped error", errBit, 1);
      check("unmapped data", rdVal, 32'h0);
      $display("register test done");
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `EWAC_OFS_SDRAM_WAIT, 32'(i % 4));
         gap(i >= 4, idleTab[i % 4]);
      end
      $display("idle gap test done");
      @(posedge clock);
      area5CardMode <= 1'b1;
      area6CardMode <= 1'b1;
      // Only codes 0 to 7 are ever programmed
      for (int d = 0; d < 8; d++) begin
         apb(1'b1, `EWAC_OFS_CARD5,
            32'(d % 4) << 20 | 32'(d) << 11);
         apb(1'b1, `EWAC_OFS_CARD6,
            32'(3 - d % 4) << 20 | 32'(7 - d) << 11);
         card(1'b0, d >= 4, d % 2, d >= 4 ? d[1] : d[0], 3'(d));
         card(1'b1, d < 4, ~d[0], d < 4 ? ~d[1] : ~d[0], 3'(7 - d));
      end
      @(posedge clock);
      area6CardMode <= 1'b0;
      apb(1'b1, `EWAC_OFS_CARD6, 32'h00300000);
      card(1'b1, 1'b1, 1'b0, 1'b0, 3'h0);
      $display("card test done");
      wrap_up();
   end
endmodule
